//--- src/nv_access_pkg.sv
// constants shared by the data eeprom byte access controller
package nv_access_pkg;

  // ****************************************************************
  // i/o register offsets
  // ****************************************************************
  localparam logic [5:0] NV_ADDR_HIGH_OFS = 6'h1F;
  localparam logic [5:0] NV_ADDR_LOW_OFS  = 6'h1E;
  localparam logic [5:0] NV_DATA_OFS      = 6'h1D;
  localparam logic [5:0] NV_CTRL_OFS      = 6'h1C;

  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int READ_STROBE_BIT  = 0;
  localparam int WRITE_STROBE_BIT = 1;
  localparam int WRITE_UNLOCK_BIT = 2;
  localparam int READY_IE_BIT     = 3;
  localparam logic [3:0] CTRL_RESERVED_VAL = 4'h0;
  localparam logic [6:0] ADDR_HIGH_RESERVED_VAL = 7'h00;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [8:0] NV_ADDR_RESET = 9'h000;
  localparam logic [7:0] NV_DATA_RESET = 8'h00;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS    = 40;
  localparam int OSC_PERIOD_NS    = 1000;
  localparam int OSC_DIV_CYCLES   = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UNLOCK_CYCLES    = 4;
  localparam int WRITE_HALT_CYCLES = 2;
  localparam int READ_HALT_CYCLES  = 4;
  localparam int NV_DEPTH         = 512;
  localparam int NV_WRITE_OSC_CYCLES = 8448;

  // ****************************************************************
  // write engine states
  // ****************************************************************
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b01,
    ENG_PROG = 2'b10
  } eng_state_t;

endpackage : nv_access_pkg

//--- src/nv_byte_access.sv
// data eeprom byte access controller: i/o registers, unlock, timed write, stall
module nv_byte_access
  import nv_access_pkg::*;
#(
  parameter int ADDR_W           = 9,
  parameter int WRITE_OSC_CYCLES = NV_WRITE_OSC_CYCLES
) (
  // clock and resets
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       por_i,
  // i/o register port from the core
  input  wire logic [5:0] io_addr_i,
  input  wire logic       io_wr_i,
  input  wire logic       io_rd_i,
  input  wire logic [7:0] io_wdata_i,
  output logic      [7:0] io_rdata_o,
  // core interaction
  input  wire logic       global_ie_i,
  input  wire logic       power_down_i,
  output logic            cpu_halt_o,
  output logic            ready_irq_o,
  output logic            osc_run_o
);

  // counter sized from the parameter, so short write lengths stay cheap
  localparam int WCNT_W = $clog2(WRITE_OSC_CYCLES + 1);
  localparam int DCNT_W = $clog2(OSC_DIV_CYCLES + 1);

  // refuse an address width the address map cannot serve, and a write length below one
  if (ADDR_W != 9) begin : g_bad_addr
    $error("nv_byte_access: address width must be 9");
  end
  if (WRITE_OSC_CYCLES < 1) begin : g_bad_wcnt
    $error("nv_byte_access: write length must be at least one");
  end

  // ****************************************************************
  // storage array
  // ****************************************************************
  logic [7:0] nv_mem [NV_DEPTH];

  // ****************************************************************
  // register bus decode
  // ****************************************************************
  logic wr_high;
  logic wr_low;
  logic wr_data;
  logic wr_ctrl;

  // strobes for each register
  assign wr_high = io_wr_i && (io_addr_i == NV_ADDR_HIGH_OFS);
  assign wr_low  = io_wr_i && (io_addr_i == NV_ADDR_LOW_OFS);
  assign wr_data = io_wr_i && (io_addr_i == NV_DATA_OFS);
  assign wr_ctrl = io_wr_i && (io_addr_i == NV_CTRL_OFS);

  // ****************************************************************
  // control and data registers
  // ****************************************************************
  logic [ADDR_W-1:0] nv_byte_address_reg;
  logic [ADDR_W-1:0] nv_byte_address_next;
  logic [7:0]        nv_byte_data_reg;
  logic [7:0]        nv_byte_data_next;
  logic              ready_interrupt_enable_reg;
  logic              ready_interrupt_enable_next;
  logic              write_unlock_reg;
  logic              write_unlock_next;
  logic [2:0]        unlock_cnt_reg;
  logic [2:0]        unlock_cnt_next;
  logic [2:0]        halt_cnt_reg;
  logic [2:0]        halt_cnt_next;
  logic [7:0]        rdata_reg;
  logic [7:0]        rdata_next;

  // engine side
  eng_state_t        eng_state_reg;
  eng_state_t        eng_state_next;
  logic [WCNT_W-1:0] wcnt_reg;
  logic [WCNT_W-1:0] wcnt_next;
  logic [DCNT_W-1:0] div_cnt_reg;
  logic [DCNT_W-1:0] div_cnt_next;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [ADDR_W-1:0] wr_addr_next;
  logic [7:0]        wr_byte_reg;
  logic [7:0]        wr_byte_next;

  logic busy;
  logic start_write;
  logic do_read;
  logic osc_tick;
  logic mem_we;

  // busy is the strobe bit software polls; no second flop to drift out of step
  assign busy = (eng_state_reg == ENG_PROG);

  // strobe honoured only while unlock still armed
  assign start_write = wr_ctrl && io_wdata_i[WRITE_STROBE_BIT] && write_unlock_reg && !busy;
  // read strobe ignored during a write
  assign do_read = wr_ctrl && io_wdata_i[READ_STROBE_BIT] && !busy;

  // control register image; strobe reads engine, read strobe reads zero
  function automatic logic [7:0] ctrl_image(input logic rie, input logic unl, input logic bsy);
    ctrl_image = {CTRL_RESERVED_VAL, rie, unl, bsy, 1'b0};
  endfunction : ctrl_image

  // next values of the core-facing registers
  always_comb begin
    nv_byte_address_next        = nv_byte_address_reg;
    nv_byte_data_next           = nv_byte_data_reg;
    ready_interrupt_enable_next = ready_interrupt_enable_reg;
    write_unlock_next           = write_unlock_reg;
    unlock_cnt_next             = unlock_cnt_reg;
    halt_cnt_next               = (halt_cnt_reg != 3'h0) ? halt_cnt_reg - 3'h1 : 3'h0;
    rdata_next                  = rdata_reg;
    // address frozen while a write runs
    if (wr_high && !busy) begin
      nv_byte_address_next[ADDR_W-1] = io_wdata_i[0];
    end
    if (wr_low && !busy) begin
      nv_byte_address_next[7:0] = io_wdata_i;
    end
    // data register holds the byte to write
    if (wr_data) begin
      nv_byte_data_next = io_wdata_i;
    end
    // re-arming an armed window does not restart it, so it never outlives four cycles
    // unlock times out after four cycles
    if (write_unlock_reg) begin
      if (unlock_cnt_reg == 3'(UNLOCK_CYCLES - 1)) begin
        write_unlock_next = 1'b0;
      end else begin
        unlock_cnt_next = unlock_cnt_reg + 3'h1;
      end
    end
    if (wr_ctrl) begin
      ready_interrupt_enable_next = io_wdata_i[READY_IE_BIT];
      if (io_wdata_i[WRITE_UNLOCK_BIT] && !write_unlock_reg) begin
        write_unlock_next = 1'b1;
        unlock_cnt_next   = 3'h0;
      end else if (!io_wdata_i[WRITE_UNLOCK_BIT]) begin
        write_unlock_next = 1'b0;
      end
    end
    // unlock is consumed by the write it enables
    if (start_write) begin
      write_unlock_next = 1'b0;
      halt_cnt_next     = 3'(WRITE_HALT_CYCLES);
    end
    // byte fetched in the strobe cycle
    if (do_read) begin
      nv_byte_data_next = nv_mem[nv_byte_address_reg];
      halt_cnt_next     = 3'(READ_HALT_CYCLES);
    end
    // read data registered so io_rdata_o stands until the next read
    // registered read port; unmapped offsets read zero
    if (io_rd_i) begin
      case (io_addr_i)
        NV_ADDR_HIGH_OFS: rdata_next = {ADDR_HIGH_RESERVED_VAL, nv_byte_address_reg[ADDR_W-1]};
        NV_ADDR_LOW_OFS:  rdata_next = nv_byte_address_reg[7:0];
        NV_DATA_OFS:      rdata_next = nv_byte_data_reg;
        NV_CTRL_OFS:      rdata_next = ctrl_image(ready_interrupt_enable_reg, write_unlock_reg, busy);
        default:          rdata_next = 8'h00;
      endcase
    end
  end

  // core-facing registers; address has a safe value even though software must set it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // address given a known start by system reset, though software must set it
      nv_byte_address_reg        <= NV_ADDR_RESET;
      nv_byte_data_reg           <= NV_DATA_RESET;
      ready_interrupt_enable_reg <= 1'b0;
      write_unlock_reg           <= 1'b0;
      unlock_cnt_reg             <= 3'h0;
      halt_cnt_reg               <= 3'h0;
      rdata_reg                  <= 8'h00;
    end else begin
      nv_byte_address_reg        <= nv_byte_address_next;
      nv_byte_data_reg           <= nv_byte_data_next;
      ready_interrupt_enable_reg <= ready_interrupt_enable_next;
      write_unlock_reg           <= write_unlock_next;
      unlock_cnt_reg             <= unlock_cnt_next;
      halt_cnt_reg               <= halt_cnt_next;
      rdata_reg                  <= rdata_next;
    end
  end

  // ****************************************************************
  // timed write engine
  // ****************************************************************

  // limitation: tick derives from clk_i, so write time assumes the 25 MHz clock
  // 1 MHz tick from the core clock stands in for the rc oscillator
  assign osc_tick = (div_cnt_reg == DCNT_W'(OSC_DIV_CYCLES - 1));

  // next values of the write engine
  always_comb begin
    eng_state_next = eng_state_reg;
    wcnt_next      = wcnt_reg;
    wr_addr_next   = wr_addr_reg;
    wr_byte_next   = wr_byte_reg;
    div_cnt_next   = div_cnt_reg;
    mem_we         = 1'b0;
    // divider ticks only while a write runs and is held at zero otherwise, whatever the sleep state
    if (busy) begin
      div_cnt_next = osc_tick ? '0 : div_cnt_reg + DCNT_W'(1);
    end else begin
      div_cnt_next = '0;
    end
    case (eng_state_reg)
      ENG_IDLE: begin
        if (start_write) begin
          // byte and address captured at start
          wr_addr_next   = nv_byte_address_reg;
          wr_byte_next   = nv_byte_data_reg;
          wcnt_next      = '0;
          eng_state_next = ENG_PROG;
        end
      end
      ENG_PROG: begin
        // address and byte latched at start; later register writes cannot disturb them
        if (osc_tick) begin
          // write spans the full oscillator count
          if (wcnt_reg == WCNT_W'(WRITE_OSC_CYCLES - 1)) begin
            mem_we = 1'b1;
            // strobe clears when write time ends
            eng_state_next = ENG_IDLE;
          end else begin
            wcnt_next = wcnt_reg + WCNT_W'(1);
          end
        end
      end
      default: eng_state_next = ENG_IDLE;
    endcase
  end

  // only power-on reset stops the engine, system reset does not
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      eng_state_reg <= ENG_IDLE;
      wcnt_reg      <= '0;
      div_cnt_reg   <= '0;
      wr_addr_reg   <= NV_ADDR_RESET;
      wr_byte_reg   <= NV_DATA_RESET;
    end else begin
      eng_state_reg <= eng_state_next;
      wcnt_reg      <= wcnt_next;
      div_cnt_reg   <= div_cnt_next;
      wr_addr_reg   <= wr_addr_next;
      wr_byte_reg   <= wr_byte_next;
    end
  end

  // contents not initialised; a never-written byte reads unknown
  // array write port, separate so the array maps to a memory
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      nv_mem[wr_addr_reg] <= wr_byte_reg;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  // a level, not a flag, so a handler has nothing to clear
  // level interrupt while ready and enabled
  assign ready_irq_o = ready_interrupt_enable_reg && global_ie_i && !busy;
  assign cpu_halt_o  = (halt_cnt_reg != 3'h0);
  // oscillator held on by a running write, sleep or not
  assign osc_run_o   = busy || !power_down_i;
  assign io_rdata_o  = rdata_reg;

endmodule : nv_byte_access

//--- sim/nv_access_assertions.sv
// port checker for the eeprom byte access controller
module nv_access_assertions
  import nv_access_pkg::*;
(
  // clock and resets
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       por_i,
  // register port
  input wire logic [5:0] io_addr_i,
  input wire logic       io_wr_i,
  input wire logic       io_rd_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] io_rdata_o,
  // core side
  input wire logic       global_ie_i,
  input wire logic       power_down_i,
  input wire logic       cpu_halt_o,
  input wire logic       ready_irq_o,
  input wire logic       osc_run_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****************************************
  // register, stall and request checks
  // ****************************************
  ctrl_rsv_a:
    assert property (io_rd_i && io_addr_i == NV_CTRL_OFS |=> io_rdata_o[7:4] == CTRL_RESERVED_VAL && !io_rdata_o[0])
    else $error("control read shows reserved or read bit");
  addr_rsv_a:
    assert property (io_rd_i && io_addr_i == NV_ADDR_HIGH_OFS |=> io_rdata_o[7:1] == ADDR_HIGH_RESERVED_VAL)
    else $error("address high read shows reserved bits");
  rdata_hold_a:
    assert property (!$past(io_rd_i) && !$past(rst_i) |-> $stable(io_rdata_o))
    else $error("read data moved without a read");
  halt_min_a:
    assert property ($rose(cpu_halt_o) |-> cpu_halt_o[*2])
    else $error("stall shorter than two cycles");
  halt_max_a:
    assert property (cpu_halt_o[*4] |=> !cpu_halt_o)
    else $error("stall longer than four cycles");
  read_halt_a:
    assert property (io_wr_i && io_addr_i == NV_CTRL_OFS && io_wdata_i[2:0] == 3'b001 && ready_irq_o
                     |=> cpu_halt_o[*4] ##1 !cpu_halt_o)
    else $error("read stall not four cycles");
  irq_gate_a:
    assert property (!global_ie_i |-> !ready_irq_o)
    else $error("ready request without global enable");
  irq_off_a:
    assert property (io_wr_i && io_addr_i == NV_CTRL_OFS && !io_wdata_i[READY_IE_BIT] |=> !ready_irq_o)
    else $error("ready request after enable cleared");
  osc_run_a:
    assert property (!power_down_i |-> osc_run_o)
    else $error("oscillator stopped while awake");
endmodule : nv_access_assertions

bind nv_byte_access nv_access_assertions i_nv_access_assertions (
  .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
  .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .global_ie_i(global_ie_i),
  .power_down_i(power_down_i), .cpu_halt_o(cpu_halt_o), .ready_irq_o(ready_irq_o), .osc_run_o(osc_run_o));

//--- sim/nv_core_model.sv
// processor core model issuing i/o register accesses
module nv_core_model
  import nv_access_pkg::*;
(
  // clock and stall
  input  wire logic       clk_i,
  input  wire logic       halt_i,
  // i/o register port
  input  wire logic [7:0] rdata_i,
  output logic      [5:0] addr_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_o = 6'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // ****************************************
  // accesses; a stalled core issues nothing
  // ****************************************
  task automatic issue(input logic [5:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    @(negedge clk_i);
    while (halt_i) @(negedge clk_i);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    wdata_o <= ~d; // released data is not left looking valid
  endtask : issue
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    issue(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    issue(a, 1'b0, 8'h00);
    @(negedge clk_i);
    d = rdata_i;
  endtask : rd
  task automatic wait_idle();
    logic [7:0] c;
    for (int i = 0; i < 200; i++) begin
      rd(NV_CTRL_OFS, c);
      if (!c[WRITE_STROBE_BIT]) break;
    end
  endtask : wait_idle
  // address first, unlock then strobe, no flash work here, ready irq enable set by both control writes
  task automatic nv_write(input logic [8:0] a, input logic [7:0] d, input int gap);
    wait_idle();
    wr(NV_ADDR_HIGH_OFS, {7'h00, a[8]});
    wr(NV_ADDR_LOW_OFS, a[7:0]);
    wr(NV_DATA_OFS, d);
    wr(NV_CTRL_OFS, 8'h0C);
    repeat (gap) @(posedge clk_i);
    wr(NV_CTRL_OFS, 8'h0A);
  endtask : nv_write
endmodule : nv_core_model

//--- sim/tb_nv_byte_access.sv
// testbench for the eeprom byte access controller
module tb_nv_byte_access;
  import nv_access_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       por_i = 1'b1;
  logic       global_ie_i = 1'b0;
  logic       power_down_i = 1'b0;
  logic [5:0] io_addr_i;
  logic       io_wr_i;
  logic       io_rd_i;
  logic [7:0] io_wdata_i;
  logic [7:0] io_rdata_o;
  logic       cpu_halt_o;
  logic       ready_irq_o;
  logic       osc_run_o;
  logic [7:0] d;
  int         err_count = 0;
  int         num_checks = 0;
  int         cyc = 0;
  // short write time keeps each write at 100 clocks
  localparam int SIM_WOSC = 4;
  localparam int WR_CLKS  = SIM_WOSC * OSC_DIV_CYCLES;
  nv_byte_access #(.WRITE_OSC_CYCLES(SIM_WOSC)) i_nv_byte_access (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
    .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o), .global_ie_i(global_ie_i), .power_down_i(power_down_i),
    .cpu_halt_o(cpu_halt_o), .ready_irq_o(ready_irq_o), .osc_run_o(osc_run_o));
  nv_core_model i_nv_core_model (.clk_i(clk_i), .halt_i(cpu_halt_o), .rdata_i(io_rdata_o),
    .addr_o(io_addr_i), .wr_o(io_wr_i), .rd_o(io_rd_i), .wdata_o(io_wdata_i));
  // ****************************************
  // clock, timeout and reporting
  // ****************************************
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // hang guard well above the four writes
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      test_done();
    end
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    global_ie_i <= 1'b1;
    i_nv_core_model.wr(NV_ADDR_HIGH_OFS, 8'hFF);
    i_nv_core_model.rd(NV_ADDR_HIGH_OFS, d);
    chk(d, 8'h01);
    i_nv_core_model.wr(NV_CTRL_OFS, 8'hF8);
    i_nv_core_model.rd(NV_CTRL_OFS, d);
    chk(d, 8'h08);
    @(negedge clk_i);
    chk({7'h00, ready_irq_o}, 8'h01);
    i_nv_core_model.wr(NV_CTRL_OFS, 8'h0C);
    i_nv_core_model.rd(NV_CTRL_OFS, d);
    chk(d & 8'h04, 8'h04);
    i_nv_core_model.rd(NV_CTRL_OFS, d);
    chk(d & 8'h04, 8'h00);
    $display("test registers done");
    i_nv_core_model.nv_write(9'h1A5, 8'h3C, 0);
    i_nv_core_model.rd(NV_CTRL_OFS, d);
    chk(d & 8'h0B, 8'h0A);
    chk({7'h00, ready_irq_o}, 8'h00);
    i_nv_core_model.wr(NV_ADDR_LOW_OFS, 8'h00);
    i_nv_core_model.wr(NV_CTRL_OFS, 8'h09);
    i_nv_core_model.wait_idle();
    chk({7'h00, ready_irq_o}, 8'h01);
    i_nv_core_model.rd(NV_ADDR_LOW_OFS, d);
    chk(d, 8'hA5);
    i_nv_core_model.rd(NV_DATA_OFS, d);
    chk(d, 8'h3C);
    i_nv_core_model.wr(NV_DATA_OFS, 8'h00);
    i_nv_core_model.wr(NV_CTRL_OFS, 8'h09);
    @(negedge clk_i);
    chk({7'h00, cpu_halt_o}, 8'h01);
    i_nv_core_model.rd(NV_DATA_OFS, d);
    chk(d, 8'h3C);
    i_nv_core_model.rd(NV_CTRL_OFS, d);
    chk(d, 8'h08);
    $display("test write read done");
    i_nv_core_model.nv_write(9'h000, 8'h11, 1);
    i_nv_core_model.nv_write(9'h000, 8'h55, 2);
    i_nv_core_model.rd(NV_CTRL_OFS, d);
    chk(d & 8'h0B, 8'h08);
    i_nv_core_model.wr(NV_CTRL_OFS, 8'h0A);
    i_nv_core_model.rd(NV_CTRL_OFS, d);
    chk(d & 8'h0B, 8'h08);
    i_nv_core_model.nv_write(9'h1FF, 8'hE7, 0);
    repeat (WR_CLKS - 10) @(posedge clk_i);
    i_nv_core_model.rd(NV_CTRL_OFS, d);
    chk(d & 8'h02, 8'h02);
    repeat (10) @(posedge clk_i);
    i_nv_core_model.rd(NV_CTRL_OFS, d);
    chk(d & 8'h02, 8'h00);
    i_nv_core_model.wait_idle();
    i_nv_core_model.wr(NV_CTRL_OFS, 8'h01);
    i_nv_core_model.rd(NV_DATA_OFS, d);
    chk(d, 8'hE7);
    i_nv_core_model.wr(NV_ADDR_HIGH_OFS, 8'h00);
    i_nv_core_model.wr(NV_ADDR_LOW_OFS, 8'h00);
    i_nv_core_model.wr(NV_CTRL_OFS, 8'h01);
    i_nv_core_model.rd(NV_DATA_OFS, d);
    chk(d, 8'h11);
    $display("test unlock window done");
    i_nv_core_model.nv_write(9'h0F0, 8'hC3, 1);
    @(posedge clk_i);
    power_down_i <= 1'b1;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({7'h00, osc_run_o}, 8'h01);
    i_nv_core_model.rd(NV_CTRL_OFS, d);
    chk(d & 8'h02, 8'h02);
    i_nv_core_model.wait_idle();
    chk({7'h00, osc_run_o}, 8'h00);
    @(posedge clk_i);
    power_down_i <= 1'b0;
    i_nv_core_model.wr(NV_ADDR_LOW_OFS, 8'hF0);
    i_nv_core_model.wr(NV_CTRL_OFS, 8'h01);
    i_nv_core_model.rd(NV_DATA_OFS, d);
    chk(d, 8'hC3);
    $display("test reset power down done");
    test_done();
  end
endmodule : tb_nv_byte_access
